// ### hdl/nested_irq_ctrl.sv
// nested interrupt controller with supply warning monitor and reset flags
// Functional notes
// - warning flag follows the comparator live, read only, writes ignored
// - with enable set, each change of the warning flag raises a request
// - warning request cleared automatically when its vector is taken
// - warning detector, flag and request work only with undervoltage option on
// - no warning request while the reset delay of 256 or 4096 cycles runs
// - enabling while flag is set gives a request at enable time
// - warning wakes the core from wait but never from halt
// - supply monitor register is frozen while in halt
// - low voltage reset flag set by that reset, cleared only by writing zero or by power-on reset
// - watchdog flag set by watchdog reset, cleared by zero write or lv reset
// - reserved supply monitor bits read zero; software writes zero
// - level bits encode 0 as 10, 1 as 01, 2 as 00, 3 as 11
// - at instruction end push context, load vector level, fetch vector
// - interrupt return restores level bits from the stack
// - highest software level wins, ties by fixed hardware priority
// - unserved requests stay pending until they become highest
// - reset and trap ignore level bits, set level 3, wake from halt
// - trap taken on its instruction, top level may preempt trap routine
// - maskable served only if its level exceeds current; warning and peripheral requests also need their enable, edge lines have none
// - top level triggers on chosen pin edge, ranks above software levels
// - edge external lines latched, cleared on entry, pins of a line ORed
// - peripheral request is flag and enable; clearing flag drops it
// - up to 16 fixed vectors at top of memory and four levels
// - hardware order lowest to highest: main, levels four to zero, top
//
// The placing of the registers and the address-and-strobe port were decided locally.
module nested_irq_ctrl
    import nic_pkg::*;
(
    input  wire logic                    clk,           // cpu clock
    input  wire logic                    rst_n,         // system reset, active low
    input  wire logic                    por_n,         // power-on reset, active low
    input  wire logic [7:0]              reg_addr,      // register address
    input  wire logic [7:0]              reg_wdata,     // register write data
    input  wire logic                    reg_wr,        // register write strobe
    input  wire logic                    reg_rd,        // register read strobe
    output logic      [7:0]              reg_rdata,     // read data, cycle after strobe
    input  wire logic                    udv_enable,    // undervoltage option on
    input  wire logic                    delay_long,    // reset delay option
    input  wire logic                    supply_low,    // comparator, high below threshold
    input  wire logic                    cause_udv,     // last reset was low voltage
    input  wire logic                    cause_wdg,     // last reset was watchdog
    input  wire logic                    top_pin,       // top level pin
    input  wire logic [NUM_EXT_PINS-1:0] ext_pins,      // edge external pins
    input  wire logic [NUM_VEC-1:0]      periph_req,    // flag and enable per vector
    input  wire logic                    insn_end,      // instruction boundary
    input  wire logic                    trap_exec,     // trap instruction at boundary
    input  wire logic                    ret_exec,      // return at boundary
    input  wire logic [1:0]              ret_level,     // level bits popped
    input  wire logic                    level_load,    // core writes level bits
    input  wire logic [1:0]              level_wdata,   // level bits from core
    input  wire logic                    wait_mode,     // core in wait
    input  wire logic                    halt_mode,     // core in halt
    output logic      [1:0]              level_bits,    // current level bits
    output logic                         stack_push,    // save context pulse
    output logic                         vector_load,   // fetch vector pulse
    output logic      [15:0]             vector_addr,   // vector to fetch
    output logic                         core_wake      // wake request
);

    logic [7:0]         rdata_r;
    logic [31:0]        prio_r;
    logic               top_rise_r;
    logic               warn_ie_r;
    logic               warn_flag_r;
    logic               warn_pend_r;
    logic               lv_rst_r;
    logic               wd_rst_r;
    logic               rst_seen_r;
    logic [12:0]        boot_cnt_r;
    logic               boot_done_r;
    logic [1:0]         lvl_r;
    logic               push_r;
    logic               vload_r;
    logic [15:0]        vaddr_r;
    logic               top_prev_r;
    logic [NUM_VEC-1:0] pend;
    logic [NUM_VEC-1:0] elig;
    logic [2:0]         vlvl [NUM_VEC];
    logic [2:0]         cur_lvl;
    logic [2:0]         best_lvl;
    logic [3:0]         best_idx;
    logic               best_ok;
    logic               take_now;
    logic               take_irq;
    logic               wr_supply;
    logic               warn_live;
    logic               warn_set;
    logic [12:0]        boot_len;

    // level bits to a number 0..3
    function automatic logic [2:0] level_of(input logic [1:0] b);
        logic [2:0] l;
        l = 3'h0;
        case (b)
            LVL0_BITS: l = 3'h0;
            LVL1_BITS: l = 3'h1;
            LVL2_BITS: l = 3'h2;
            LVL3_BITS: l = 3'h3;
            default:   l = 3'h3;
        endcase
        return l;
    endfunction

    // merge a priority byte; a level 0 field keeps the stored value
    function automatic logic [7:0] prio_merge(input logic [7:0] old_v,
                                              input logic [7:0] new_v);
        logic [7:0] m;
        m = old_v;
        for (int f = 0; f < 4; f++) begin
            if (new_v[2*f+:2] != LVL0_BITS) begin
                m[2*f+:2] = new_v[2*f+:2];
            end
        end
        return m;
    endfunction

    assign wr_supply = reg_wr && (reg_addr == ADDR_SUPPLY);
    assign warn_live = udv_enable && supply_low;
    assign boot_len  = delay_long ? DELAY_LONG : DELAY_SHORT;
    assign cur_lvl   = level_of(lvl_r);

    // reset delay counter; vectors are held off until it ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt_r  <= BOOT_RST;
            boot_done_r <= 1'b0;
        end else if (!boot_done_r) begin
            boot_cnt_r <= 13'(boot_cnt_r + 13'h0001);
            if (boot_cnt_r == 13'(boot_len - 13'h0001)) begin
                boot_done_r <= 1'b1;
            end
        end
    end

    // marks the first edge after release so the reset cause is caught once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_seen_r <= 1'b0;
        end else begin
            rst_seen_r <= 1'b1;
        end
    end

    // reset source flags live on power-on reset only, so they survive rst_n
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            lv_rst_r <= 1'b0;
            wd_rst_r <= 1'b0;
        end else if (!rst_seen_r && rst_n) begin
            if (cause_udv) begin
                lv_rst_r <= 1'b1;
                wd_rst_r <= 1'b0;
            end else if (cause_wdg) begin
                wd_rst_r <= 1'b1;
            end
        end else if (wr_supply && !halt_mode) begin
            if (!reg_wdata[BIT_LV_RST]) begin
                lv_rst_r <= 1'b0;
            end
            if (!reg_wdata[BIT_WD_RST]) begin
                wd_rst_r <= 1'b0;
            end
        end
    end

    // warning enable, written by software, held in halt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warn_ie_r <= SUPPLY_RST[BIT_WARN_IE];
        end else if (wr_supply && !halt_mode) begin
            warn_ie_r <= reg_wdata[BIT_WARN_IE];
        end
    end

    // live flag one cycle behind the comparator; frozen in halt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warn_flag_r <= SUPPLY_RST[BIT_WARN_FLAG];
        end else if (!halt_mode) begin
            warn_flag_r <= warn_live;
        end
    end

    // a change of the flag, or enabling while low, makes a request;
    // changes inside the reset delay are swallowed on purpose
    always_comb begin
        warn_set = 1'b0;
        if (boot_done_r && !halt_mode && udv_enable) begin
            if (warn_ie_r && (warn_live != warn_flag_r)) begin
                warn_set = 1'b1;
            end
            if (wr_supply && reg_wdata[BIT_WARN_IE] && !warn_ie_r && warn_live) begin
                warn_set = 1'b1;
            end
        end
    end

    // pending warning; a new change beats the entry clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warn_pend_r <= 1'b0;
        end else if (warn_set) begin
            warn_pend_r <= 1'b1;
        end else if (!udv_enable) begin
            warn_pend_r <= 1'b0;
        end else if (take_irq && best_idx == 4'(VEC_SUPPLY)) begin
            warn_pend_r <= 1'b0;
        end
    end

    // priority registers; top nibble of the last reads as ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_r <= PRIO_RST;
        end else if (reg_wr && reg_addr >= ADDR_PRIO0 && reg_addr <= ADDR_PRIO3) begin
            case (reg_addr)
                8'h01:   prio_r[7:0]   <= prio_merge(prio_r[7:0], reg_wdata);
                8'h02:   prio_r[15:8]  <= prio_merge(prio_r[15:8], reg_wdata);
                8'h03:   prio_r[23:16] <= prio_merge(prio_r[23:16], reg_wdata);
                8'h04:   prio_r[31:24] <= prio_merge(prio_r[31:24], reg_wdata)
                                          | PRIO3_RO_MASK;
                default: prio_r        <= prio_r;
            endcase
        end
    end

    // top level edge select, 1 picks rising
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_rise_r <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_TOP_CFG) begin
            top_rise_r <= reg_wdata[0];
        end
    end

    // previous top pin level; resets low so the falling default sees no edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_prev_r <= 1'b0;
        end else begin
            top_prev_r <= top_pin;
        end
    end

    // per vector: request source, software level, eligibility
    for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
        if (v == VEC_TOP) begin : g_top
            logic lat_r;
            logic hit;
            assign hit = top_rise_r ? (top_pin && !top_prev_r)
                                    : (!top_pin && top_prev_r);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lat_r <= 1'b0;
                end else if (hit) begin
                    lat_r <= 1'b1;
                end else if (take_irq && best_idx == 4'(v)) begin
                    lat_r <= 1'b0;
                end
            end
            assign pend[v] = lat_r;
            assign vlvl[v] = LVL_TOP;
        end else if (EDGE_MASK[v]) begin : g_edge
            logic       lat_r;
            logic       prev_r;
            logic       line;
            assign line = |ext_pins[2*(v-VEC_EXT_LO)+:2];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev_r <= 1'b0;
                    lat_r  <= 1'b0;
                end else begin
                    prev_r <= line;
                    if (line && !prev_r) begin
                        lat_r <= 1'b1;
                    end else if (take_irq && best_idx == 4'(v)) begin
                        lat_r <= 1'b0;
                    end
                end
            end
            assign pend[v] = lat_r;
            assign vlvl[v] = level_of(prio_r[2*v+:2]);
        end else if (v == VEC_SUPPLY) begin : g_sup
            assign pend[v] = warn_pend_r && warn_ie_r;
            assign vlvl[v] = level_of(prio_r[2*v+:2]);
        end else begin : g_per
            assign pend[v] = periph_req[v];
            assign vlvl[v] = level_of(prio_r[2*v+:2]);
        end
        assign elig[v] = pend[v] && (vlvl[v] > cur_lvl);
    end

    // highest level first; scanning downwards lets the lower index win ties
    always_comb begin
        best_lvl = 3'h0;
        best_idx = 4'h0;
        best_ok  = 1'b0;
        for (int v = NUM_VEC - 1; v >= 0; v--) begin
            if (elig[v] && (!best_ok || vlvl[v] >= best_lvl)) begin
                best_lvl = vlvl[v];
                best_idx = 4'(v);
                best_ok  = 1'b1;
            end
        end
    end

    // return and level loads own their boundary; requests wait one more
    assign take_now = insn_end && boot_done_r && !ret_exec && !level_load;
    assign take_irq = take_now && !trap_exec && best_ok;

    // current level bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_r <= LVL3_BITS;
        end else if (take_now && trap_exec) begin
            lvl_r <= LVL3_BITS;
        end else if (take_irq) begin
            lvl_r <= (best_idx == 4'(VEC_TOP)) ? LVL3_BITS
                                               : prio_r[2*best_idx+:2];
        end else if (insn_end && ret_exec) begin
            lvl_r <= ret_level;
        end else if (insn_end && level_load) begin
            lvl_r <= level_wdata;
        end
    end

    // context save and vector fetch pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_r  <= 1'b0;
            vload_r <= 1'b0;
            vaddr_r <= VEC_RESET;
        end else begin
            push_r  <= 1'b0;
            vload_r <= 1'b0;
            if (!boot_done_r && boot_cnt_r == 13'(boot_len - 13'h0001)) begin
                vload_r <= 1'b1;
                vaddr_r <= VEC_RESET;
            end else if (take_now && trap_exec) begin
                push_r  <= 1'b1;
                vload_r <= 1'b1;
                vaddr_r <= VEC_TRAP;
            end else if (take_irq) begin
                push_r  <= 1'b1;
                vload_r <= 1'b1;
                vaddr_r <= 16'(VEC_BASE - {11'h000, best_idx, 1'b0});
            end
        end
    end

    // wait wakes on any servable request; halt only on halt-capable lines
    assign core_wake = (wait_mode && |elig)
                     || (halt_mode && |(pend & HALT_MASK));

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_SUPPLY:  rdata_r <= {1'b0, warn_ie_r, warn_flag_r,
                                         lv_rst_r, 3'h0, wd_rst_r};
                8'h01:        rdata_r <= prio_r[7:0];
                8'h02:        rdata_r <= prio_r[15:8];
                8'h03:        rdata_r <= prio_r[23:16];
                ADDR_PRIO3:   rdata_r <= prio_r[31:24] | PRIO3_RO_MASK;
                ADDR_TOP_CFG: rdata_r <= {7'h00, top_rise_r};
                default:      rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata   = rdata_r;
    assign level_bits  = lvl_r;
    assign stack_push  = push_r;
    assign vector_load = vload_r;
    assign vector_addr = vaddr_r;

endmodule // nested_irq_ctrl

// ### hdl/nic_pkg.sv
// constants shared by the nested interrupt controller and its supply monitor
package nic_pkg;
    // register port addresses
    localparam logic [7:0]  ADDR_SUPPLY   = 8'h00;
    localparam logic [7:0]  ADDR_PRIO0    = 8'h01;
    localparam logic [7:0]  ADDR_PRIO3    = 8'h04;
    localparam logic [7:0]  ADDR_TOP_CFG  = 8'h05;
    // supply monitor register fields
    localparam int          BIT_WARN_IE   = 6;
    localparam int          BIT_WARN_FLAG = 5;
    localparam int          BIT_LV_RST    = 4;
    localparam int          BIT_WD_RST    = 0;
    localparam logic [7:0]  SUPPLY_RST    = 8'h00;
    // priority registers, two bits per vector
    localparam logic [31:0] PRIO_RST      = 32'hFFFF_FFFF;
    localparam logic [7:0]  PRIO3_RO_MASK = 8'hF0;
    localparam logic [1:0]  LVL0_BITS     = 2'b10;
    localparam logic [1:0]  LVL1_BITS     = 2'b01;
    localparam logic [1:0]  LVL2_BITS     = 2'b00;
    localparam logic [1:0]  LVL3_BITS     = 2'b11;
    localparam logic [2:0]  LVL_TOP       = 3'h4;
    // vector map
    localparam int          NUM_VEC       = 14;
    localparam int          VEC_TOP       = 0;
    localparam int          VEC_EXT_LO    = 2;
    localparam int          NUM_EXT_PINS  = 8;
    localparam int          VEC_SUPPLY    = 9;
    localparam logic [13:0] EDGE_MASK     = 14'h003C;
    localparam logic [13:0] HALT_MASK     = 14'h003F;
    localparam logic [15:0] VEC_RESET     = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP      = 16'hFFFC;
    localparam logic [15:0] VEC_BASE      = 16'hFFFA;
    // reset delay in cpu cycles
    localparam logic [12:0] DELAY_SHORT   = 13'h0100;
    localparam logic [12:0] DELAY_LONG    = 13'h1000;
    localparam logic [12:0] BOOT_RST      = 13'h0000;
endpackage : nic_pkg

// ### tb/core_model.sv
// processor core side: instruction boundaries and entry observation
module core_model (
    input  wire logic       clk,         // cpu clock
    output logic            insn_end,    // instruction boundary
    output logic            trap_exec,   // trap at boundary
    output logic            ret_exec,    // return at boundary
    output logic [1:0]      ret_level,   // popped level bits
    output logic            level_load,  // level write at boundary
    output logic [1:0]      level_wdata, // level bits to write
    input  wire logic       stack_push,  // save context pulse
    input  wire logic       vector_load  // fetch vector pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {insn_end, trap_exec, ret_exec, level_load} = 4'h0;
        ret_level   = 2'b11;
        level_wdata = 2'b11;
    end
    // one boundary pulse; entry seen in the cycle after it
    task automatic boundary(input logic tr, input logic ir, input logic ll,
                            input logic [1:0] lv, output logic took);
        @(posedge clk);
        insn_end    <= 1'b1;
        trap_exec   <= tr;
        ret_exec    <= ir;
        ret_level   <= lv;
        level_load  <= ll;
        level_wdata <= lv;
        @(posedge clk);
        {insn_end, trap_exec, ret_exec, level_load} <= 4'h0;
        // context save and fetch pair up, else treat as not taken
        #1 took = stack_push & vector_load;
    endtask
endmodule // core_model

// ### tb/irq_ctrl_monitor.sv
// concurrent checks on the interrupt controller ports
module irq_ctrl_monitor
    import nic_pkg::*;
(
    input wire logic        clk,         // cpu clock
    input wire logic        rst_n,       // system reset, active low
    input wire logic        reg_rd,      // read strobe
    input wire logic [7:0]  reg_addr,    // register address
    input wire logic [7:0]  reg_rdata,   // read data
    input wire logic        insn_end,    // instruction boundary
    input wire logic        ret_exec,    // return at boundary
    input wire logic [1:0]  ret_level,   // popped level bits
    input wire logic        level_load,  // core writes level bits
    input wire logic [1:0]  level_bits,  // current level bits
    input wire logic        stack_push,  // save context pulse
    input wire logic        vector_load, // fetch vector pulse
    input wire logic [15:0] vector_addr  // vector to fetch
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reserved_read_zero: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_SUPPLY
        |-> reg_rdata[7] == 1'b0 && reg_rdata[3:1] == 3'h0) else $error("reserved bits set");
    a_push_with_load: assert property (stack_push |-> vector_load)
        else $error("push without vector load");
    a_load_single: assert property (vector_load |=> !vector_load)
        else $error("vector load longer than one cycle");
    a_trap_level: assert property (vector_load && vector_addr == VEC_TRAP
        |-> level_bits == LVL3_BITS && stack_push) else $error("trap entry wrong");
    a_top_level: assert property (vector_load && vector_addr == VEC_BASE
        |-> level_bits == LVL3_BITS) else $error("top level entry wrong");
    a_return_restore: assert property (insn_end && ret_exec && !level_load
        |=> level_bits == $past(ret_level)) else $error("return level wrong");
    a_level_boundary: assert property ($changed(level_bits) |-> $past(insn_end))
        else $error("level changed off boundary");
    a_vector_range: assert property (vector_load
        |-> vector_addr >= 16'hFFE0 && vector_addr[0] == 1'b0) else $error("vector out of range");
endmodule // irq_ctrl_monitor

bind nested_irq_ctrl irq_ctrl_monitor u_irq_ctrl_monitor (
    .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .insn_end(insn_end), .ret_exec(ret_exec), .ret_level(ret_level),
    .level_load(level_load), .level_bits(level_bits), .stack_push(stack_push),
    .vector_load(vector_load), .vector_addr(vector_addr));

// ### tb/nested_irq_ctrl_tb.sv
// self-checking bench for the nested interrupt controller
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module nested_irq_ctrl_tb
    import nic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, por_n = 0, reg_wr = 0, reg_rd = 0;
    logic supply_low = 0, cause_udv = 0, cause_wdg = 0, top_pin = 0;
    logic udv_enable = 1, halt_mode = 0, wait_mode = 0, core_wake;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ext_pins = 8'h00;
    logic        insn_end, trap_exec, ret_exec, level_load, stack_push, vector_load, took;
    logic [1:0]  ret_level, level_wdata, level_bits;
    logic [15:0] vector_addr;
    int err_count = 0, total_checks = 0, cycles = 0, n;

    nested_irq_ctrl u_nested_irq_ctrl (.clk(clk), .rst_n(rst_n), .por_n(por_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .udv_enable(udv_enable), .delay_long(1'b0),
        .supply_low(supply_low), .cause_udv(cause_udv), .cause_wdg(cause_wdg),
        .top_pin(top_pin), .ext_pins(ext_pins), .periph_req(14'h0000), .insn_end(insn_end),
        .trap_exec(trap_exec), .ret_exec(ret_exec), .ret_level(ret_level),
        .level_load(level_load), .level_wdata(level_wdata), .wait_mode(wait_mode),
        .halt_mode(halt_mode), .level_bits(level_bits), .stack_push(stack_push),
        .vector_load(vector_load), .vector_addr(vector_addr), .core_wake(core_wake));
    core_model u_core_model (.clk(clk), .insn_end(insn_end), .trap_exec(trap_exec),
        .ret_exec(ret_exec), .ret_level(ret_level), .level_load(level_load),
        .level_wdata(level_wdata), .stack_push(stack_push), .vector_load(vector_load));

    initial begin
        forever #4 clk = ~clk;
    end
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, exp)
    endtask
    task automatic rst(input logic l, input logic w);
        @(posedge clk);
        rst_n <= 1'b0; cause_udv <= l; cause_wdg <= w;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic entry(input logic tr, input logic ir, input logic ll, input logic [1:0] lv,
                         input logic exp_took, input logic [15:0] va, input logic [1:0] lb);
        u_core_model.boundary(tr, ir, ll, lv, took);
        `CHK(took, exp_took)
        if (exp_took) `CHK(vector_addr, va)
        `CHK(level_bits, lb)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        // reset source flags and reserved bits
        rd_chk(ADDR_SUPPLY, SUPPLY_RST);
        rd_chk(8'h3F, 8'h00);
        rst(1'b0, 1'b1);
        rd_chk(ADDR_SUPPLY, 8'h01);
        wr(ADDR_SUPPLY, 8'h00);
        rd_chk(ADDR_SUPPLY, 8'h00);
        rst(1'b0, 1'b1);
        rst(1'b1, 1'b0);
        rd_chk(ADDR_SUPPLY, 8'h10);
        rst(1'b0, 1'b1);
        rd_chk(ADDR_SUPPLY, 8'h11);
        @(posedge clk) por_n <= 1'b0;
        @(posedge clk) por_n <= 1'b1;
        rd_chk(ADDR_SUPPLY, 8'h00);
        $display("reset flag test done");
        // boot: reset vector after the short delay, level 3
        rst(1'b0, 1'b0);
        for (n = 0; n < 5000 && vector_load !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK(vector_load, 1'b1)
        `CHK(vector_addr, VEC_RESET)
        `CHK(level_bits, LVL3_BITS)
        // warning flag, enable and entry
        wr(ADDR_SUPPLY, 8'h40);
        rd_chk(ADDR_SUPPLY, 8'h40);
        @(posedge clk) supply_low <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(ADDR_SUPPLY, 8'h60);
        entry(0, 0, 1, LVL0_BITS, 0, 16'h0000, LVL0_BITS);
        entry(0, 0, 0, LVL0_BITS, 1, VEC_BASE - 16'(2 * VEC_SUPPLY), LVL3_BITS);
        entry(0, 1, 0, LVL0_BITS, 0, 16'h0000, LVL0_BITS);
        entry(0, 0, 0, LVL0_BITS, 0, 16'h0000, LVL0_BITS);
        $display("warning test done");
        // software level beats hardware order, loser stays pending
        wr(ADDR_PRIO0, 8'h7F);
        @(posedge clk);
        ext_pins <= 8'h08;
        supply_low <= 1'b0;
        repeat (3) @(posedge clk);
        entry(0, 0, 0, LVL0_BITS, 1, VEC_BASE - 16'(2 * VEC_SUPPLY), LVL3_BITS);
        entry(0, 1, 0, LVL0_BITS, 0, 16'h0000, LVL0_BITS);
        entry(0, 0, 0, LVL0_BITS, 1, VEC_BASE - 16'h0006, LVL1_BITS);
        $display("priority test done");
        // trap, then top level preempting it
        entry(1, 0, 0, LVL0_BITS, 1, VEC_TRAP, LVL3_BITS);
        wr(ADDR_TOP_CFG, 8'h01);
        @(posedge clk) top_pin <= 1'b1;
        repeat (3) @(posedge clk);
        entry(0, 0, 0, LVL0_BITS, 1, VEC_BASE, LVL3_BITS);
        $display("trap test done");
        // back to level 0; halt freezes the register and blocks the warning wake
        entry(0, 1, 0, LVL0_BITS, 0, 16'h0000, LVL0_BITS);
        @(posedge clk) halt_mode <= 1'b1;
        wr(ADDR_SUPPLY, 8'h00);
        @(posedge clk) supply_low <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(ADDR_SUPPLY, 8'h40);
        `CHK(core_wake, 1'b0)
        // leaving halt for wait lets the held change through as a wake
        @(posedge clk);
        halt_mode <= 1'b0;
        wait_mode <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK(core_wake, 1'b1)
        // option off: flag reads zero and the pending warning is dropped
        @(posedge clk) udv_enable <= 1'b0;
        rd_chk(ADDR_SUPPLY, 8'h40);
        `CHK(core_wake, 1'b0)
        $display("low power test done");
        wrap_up();
    end
endmodule // nested_irq_ctrl_tb
